// >>> hw/floppy_host_status_regs.sv
// apb register bank: status a/b, motor-select output, tape assign, command fifo
// assumes drive pins synchronous to pclk; apb3 slave, one wait state
// Function
// - offsets 0,1 read status; 2 write output; 3 tape; 4 status/rate; 5 fifo; 7 input/control
// - dump answers four cylinders, specify bytes, sector count, lock/perp, precomp track
// - sense drive status takes head/drive byte, returns status three
// - unknown command returns single byte 80h, controller idles
// - first mode status a: irq, drive absent, not step, track zero, not head
// - first mode status a: index level, write protect low-true, direction inward high
// - second mode status a: irq, dma request, inverted track zero
// - second mode status a: head direct, inverted index, protect high-true, dir inverted
// - first mode status b bit 5 mirrors output register drive-select bit 0
// - first mode status b toggles on write data and read data rising edges
// - first mode status b: inverted write enable, motor b, motor a
// - second mode status b: drive absent, selects b/a, inverted latched wd/rd/we
// - second mode status b bits 1,0 low when drive d or c selected
// - output register write-only, drives motors/selects/dma/reset; master reset clears it
// - normal mode tape register uses only bits 1 and 0
// - three-mode: bits 7:6 and 3:2 copy config eight bits 3:2 and 1:0
// - three-mode: bits 5:4 show config seven type of last selected drive
// - tape select codes map drive 1..3, zero none; drive 0 never tape
`timescale 1ns/100ps
`default_nettype none
module floppy_host_status_regs #(
  parameter int DEPTH = fdc_regs_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic master_reset_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_out,
  input wire logic dma_request_out,
  input wire logic second_drive_absent,
  input wire logic step_out,
  input wire logic track_zero_input,
  input wire logic head_out,
  input wire logic index_in,
  input wire logic write_protect_n,
  input wire logic dir_out,
  input wire logic write_data_out,
  input wire logic read_data_in,
  input wire logic write_enable_out,
  input wire logic [7:0] drive_status_3,
  output logic [7:0] motor_select_q,
  output logic [7:0] perp_setting_q,
  output logic lock_q,
  output logic standby_q
);
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [7:0] rate_q;
  logic [7:0] ccr_q;
  logic mode_q;
  logic [7:0] cfg7_q;
  logic [7:0] cfg8_q;
  logic [7:0] cfg9_q;
  logic [1:0] tape_sel_q;
  logic [1:0] last_drive_q;
  logic wd_tog_q;
  logic rd_tog_q;
  logic wd_prev_q;
  logic rd_prev_q;
  logic wd_ff_q;
  logic rd_ff_q;
  logic we_ff_q;
  logic [7:0] pcn_q [4];
  logic [7:0] spec1_q;
  logic [7:0] spec2_q;
  logic [7:0] eot_q;
  logic [7:0] precomp_start_track_q;
  logic [7:0] cmd_q;
  fdc_regs_pkg::cmd_state_t st_q;
  logic [7:0] res_q [DEPTH];
  logic [3:0] res_cnt_q, res_rd_q;
  logic [1:0] par_cnt_q;
  logic [3:0] idx;
  logic acc, wr, rd, hit;
  logic [7:0] wbyte, sa, sb, td, ms, di;
  logic [7:0] dsel;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign idx = paddr[5:2];
  assign acc = psel && penable && !pready_q;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign wbyte = pwdata[7:0];
  assign dsel = sel_bits(motor_select_q[1:0]);

  function automatic logic [7:0] sel_bits(input logic [1:0] d);
    sel_bits = 8'h00;
    sel_bits[d] = 1'b1;
  endfunction

  // status a, b layouts chosen live by mode bit
  always_comb begin
    sa = 8'h00;
    sb = 8'h00;
    if (!mode_q) begin
      sa[7] = irq_out;
      sa[6] = second_drive_absent;
      sa[5] = !step_out;
      sa[4] = track_zero_input;
      sa[3] = !head_out;
      sa[2] = index_in;
      sa[1] = write_protect_n;
      sa[0] = dir_out;
      sb[7:6] = 2'b11;
      sb[5] = motor_select_q[0];
      sb[4] = wd_tog_q;
      sb[3] = rd_tog_q;
      sb[2] = !write_enable_out;
      // motor pins are low-true, so their complement is the stored bit
      sb[1] = motor_select_q[5];
      sb[0] = motor_select_q[4];
    end else begin
      sa[7] = irq_out;
      sa[6] = dma_request_out;
      sa[5] = !step_out;
      sa[4] = !track_zero_input;
      sa[3] = head_out;
      sa[2] = !index_in;
      sa[1] = !write_protect_n;
      sa[0] = !dir_out;
      sb[7] = second_drive_absent;
      sb[6] = dsel[1];
      sb[5] = dsel[0];
      sb[4] = !wd_ff_q;
      sb[3] = !rd_ff_q;
      sb[2] = !we_ff_q;
      sb[1] = !dsel[3];
      sb[0] = !dsel[2];
    end
  end

  // upper tape bits only mean something with three-mode on
  always_comb begin
    td = {6'h00, tape_sel_q};
    if (cfg9_q[fdc_regs_pkg::CFG9_THREE_MODE_BIT]) begin
      td[7:6] = cfg8_q[3:2];
      td[5:4] = cfg7_q[{last_drive_q, 1'b1} -: 2];
      td[3:2] = cfg8_q[1:0];
    end
  end

  // main status: ready, result phase, busy
  always_comb begin
    ms = 8'h00;
    ms[7] = st_q != fdc_regs_pkg::CMD_RESULT;
    ms[5] = st_q == fdc_regs_pkg::CMD_RESULT;
    ms[4] = st_q != fdc_regs_pkg::CMD_IDLE;
  end

  assign di = {5'h1F, ccr_q[2], ccr_q[1:0]};

  // one wait state: pready rises at the edge after the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc && !hit;
      if (rd) begin
        unique case (idx)
          fdc_regs_pkg::IDX_STATUS_A: prdata_q <= {24'h0, sa};
          fdc_regs_pkg::IDX_STATUS_B: prdata_q <= {24'h0, sb};
          fdc_regs_pkg::IDX_TAPE: prdata_q <= {24'h0, td};
          fdc_regs_pkg::IDX_MAIN_RATE: prdata_q <= {24'h0, ms};
          fdc_regs_pkg::IDX_FIFO: prdata_q <= {24'h0, res_q[res_rd_q]};
          fdc_regs_pkg::IDX_DIAG_CCR: prdata_q <= {24'h0, di};
          fdc_regs_pkg::IDX_MODE: prdata_q <= {31'h0, mode_q};
          fdc_regs_pkg::IDX_CFG7: prdata_q <= {24'h0, cfg7_q};
          fdc_regs_pkg::IDX_CFG8: prdata_q <= {24'h0, cfg8_q};
          fdc_regs_pkg::IDX_CFG9: prdata_q <= {24'h0, cfg9_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end else if (acc) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  always_comb begin
    unique case (idx)
      fdc_regs_pkg::IDX_STATUS_A: hit = !pwrite;
      fdc_regs_pkg::IDX_STATUS_B: hit = !pwrite;
      fdc_regs_pkg::IDX_MOTOR_SEL: hit = pwrite;
      fdc_regs_pkg::IDX_TAPE: hit = 1'b1;
      fdc_regs_pkg::IDX_MAIN_RATE: hit = 1'b1;
      fdc_regs_pkg::IDX_FIFO: hit = 1'b1;
      fdc_regs_pkg::IDX_DIAG_CCR: hit = 1'b1;
      fdc_regs_pkg::IDX_MODE: hit = 1'b1;
      fdc_regs_pkg::IDX_CFG7: hit = 1'b1;
      fdc_regs_pkg::IDX_CFG8: hit = 1'b1;
      fdc_regs_pkg::IDX_CFG9: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // master reset pin clears output register like bus reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_select_q <= fdc_regs_pkg::MOTOR_SEL_RESET;
      last_drive_q <= 2'b00;
    end else if (master_reset_pin) begin
      motor_select_q <= fdc_regs_pkg::MOTOR_SEL_RESET;
      last_drive_q <= 2'b00;
    end else if (wr && idx == fdc_regs_pkg::IDX_MOTOR_SEL) begin
      motor_select_q <= wbyte;
      last_drive_q <= wbyte[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tape_sel_q <= 2'b00;
      rate_q <= 8'h00;
      ccr_q <= 8'h00;
      mode_q <= 1'b0;
      cfg7_q <= 8'h00;
      cfg8_q <= 8'h00;
      cfg9_q <= 8'h00;
    end else if (wr) begin
      unique case (idx)
        fdc_regs_pkg::IDX_TAPE: tape_sel_q <= wbyte[1:0];
        fdc_regs_pkg::IDX_MAIN_RATE: rate_q <= wbyte;
        fdc_regs_pkg::IDX_DIAG_CCR: ccr_q <= {5'h00, wbyte[2:0]};
        fdc_regs_pkg::IDX_MODE: mode_q <= wbyte[0];
        fdc_regs_pkg::IDX_CFG7: cfg7_q <= wbyte;
        fdc_regs_pkg::IDX_CFG8: cfg8_q <= wbyte;
        fdc_regs_pkg::IDX_CFG9: cfg9_q <= wbyte;
        default: ;
      endcase
    end
  end

  // edge toggles and latched copies of drive lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      wd_tog_q <= 1'b0;
      rd_tog_q <= 1'b0;
      wd_ff_q <= 1'b0;
      rd_ff_q <= 1'b0;
      we_ff_q <= 1'b0;
    end else begin
      wd_prev_q <= write_data_out;
      rd_prev_q <= read_data_in;
      if (write_data_out && !wd_prev_q) begin
        wd_tog_q <= !wd_tog_q;
        wd_ff_q <= 1'b1;
      end
      if (read_data_in && !rd_prev_q) begin
        rd_tog_q <= !rd_tog_q;
        rd_ff_q <= 1'b1;
      end
      if (write_enable_out) begin
        we_ff_q <= 1'b1;
      end
      if (rd && idx == fdc_regs_pkg::IDX_STATUS_B) begin
        // reading clears latches unless an edge (for we, a high level) lands the same cycle
        if (!(write_data_out && !wd_prev_q)) wd_ff_q <= 1'b0;
        if (!(read_data_in && !rd_prev_q)) rd_ff_q <= 1'b0;
        if (!write_enable_out) we_ff_q <= 1'b0;
      end
    end
  end

  // command engine: only the codes below; others give 80h
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= fdc_regs_pkg::CMD_IDLE;
      cmd_q <= 8'h00;
      par_cnt_q <= 2'b00;
      res_cnt_q <= 4'h0;
      res_rd_q <= 4'h0;
      lock_q <= 1'b0;
      perp_setting_q <= 8'h00;
      standby_q <= 1'b0;
      spec1_q <= fdc_regs_pkg::SPEC1_RESET;
      spec2_q <= fdc_regs_pkg::SPEC2_RESET;
      eot_q <= fdc_regs_pkg::EOT_RESET;
      precomp_start_track_q <= fdc_regs_pkg::PRECOMP_START_TRACK_RESET;
      for (int i = 0; i < 4; i++) pcn_q[i] <= 8'h00;
      for (int i = 0; i < DEPTH; i++) res_q[i] <= 8'h00;
    end else if (master_reset_pin || (wr && idx == fdc_regs_pkg::IDX_MOTOR_SEL && !wbyte[2])) begin
      st_q <= fdc_regs_pkg::CMD_IDLE;
      res_cnt_q <= 4'h0;
      res_rd_q <= 4'h0;
    end else begin
      unique case (st_q)
        fdc_regs_pkg::CMD_IDLE: begin
          if (wr && idx == fdc_regs_pkg::IDX_FIFO) begin
            cmd_q <= wbyte;
            standby_q <= 1'b0;
            res_rd_q <= 4'h0;
            par_cnt_q <= 2'b00;
            if (wbyte == fdc_regs_pkg::CMD_DUMPREG) begin
              res_q[0] <= pcn_q[0];
              res_q[1] <= pcn_q[1];
              res_q[2] <= pcn_q[2];
              res_q[3] <= pcn_q[3];
              res_q[4] <= spec1_q;
              res_q[5] <= spec2_q;
              res_q[6] <= eot_q;
              res_q[7] <= {lock_q, 1'b0, perp_setting_q[5:0]};
              res_q[8] <= {1'b0, perp_setting_q[7], 6'h00};
              res_q[9] <= precomp_start_track_q;
              res_cnt_q <= 4'(fdc_regs_pkg::DUMP_LEN);
              st_q <= fdc_regs_pkg::CMD_RESULT;
            end else if (wbyte[6:0] == fdc_regs_pkg::CMD_LOCK_LOW) begin
              lock_q <= wbyte[7];
              res_q[0] <= 8'(wbyte[7]) << fdc_regs_pkg::LOCK_RESULT_BIT;
              res_cnt_q <= 4'h1;
              st_q <= fdc_regs_pkg::CMD_RESULT;
            end else if (wbyte == fdc_regs_pkg::CMD_PERP
                         || wbyte == fdc_regs_pkg::CMD_SENSE
                         || wbyte == fdc_regs_pkg::CMD_SPECIFY) begin
              st_q <= fdc_regs_pkg::CMD_PARAM;
            end else begin
              res_q[0] <= fdc_regs_pkg::INVALID_ST0;
              res_cnt_q <= 4'h1;
              standby_q <= 1'b1;
              st_q <= fdc_regs_pkg::CMD_RESULT;
            end
          end
        end
        fdc_regs_pkg::CMD_PARAM: begin
          if (wr && idx == fdc_regs_pkg::IDX_FIFO) begin
            par_cnt_q <= par_cnt_q + 2'b01;
            if (cmd_q == fdc_regs_pkg::CMD_PERP) begin
              perp_setting_q <= {wbyte[7], 1'b0, wbyte[5:0]};
              st_q <= fdc_regs_pkg::CMD_IDLE;
            end else if (cmd_q == fdc_regs_pkg::CMD_SENSE) begin
              res_q[0] <= {drive_status_3[7:3], wbyte[2:0]};
              res_cnt_q <= 4'h1;
              st_q <= fdc_regs_pkg::CMD_RESULT;
            end else if (par_cnt_q == 2'b00) begin
              spec1_q <= wbyte;
            end else begin
              spec2_q <= wbyte;
              st_q <= fdc_regs_pkg::CMD_IDLE;
            end
          end
        end
        fdc_regs_pkg::CMD_RESULT: begin
          if (rd && idx == fdc_regs_pkg::IDX_FIFO) begin
            res_rd_q <= res_rd_q + 4'h1;
            if (res_rd_q + 4'h1 == res_cnt_q) st_q <= fdc_regs_pkg::CMD_IDLE;
          end
        end
        default: st_q <= fdc_regs_pkg::CMD_IDLE;
      endcase
    end
  end
endmodule // floppy_host_status_regs
`default_nettype wire

// >>> hw/fdc_regs_pkg.sv
// package of offsets, field positions, command codes and reset values
// assumes apb byte addressing with one register per 32-bit word
package fdc_regs_pkg;
  localparam logic [3:0] IDX_STATUS_A = 4'h0;
  localparam logic [3:0] IDX_STATUS_B = 4'h1;
  localparam logic [3:0] IDX_MOTOR_SEL = 4'h2;
  localparam logic [3:0] IDX_TAPE = 4'h3;
  localparam logic [3:0] IDX_MAIN_RATE = 4'h4;
  localparam logic [3:0] IDX_FIFO = 4'h5;
  localparam logic [3:0] IDX_DIAG_CCR = 4'h7;
  localparam logic [3:0] IDX_MODE = 4'h8;
  localparam logic [3:0] IDX_CFG7 = 4'h9;
  localparam logic [3:0] IDX_CFG8 = 4'hA;
  localparam logic [3:0] IDX_CFG9 = 4'hB;
  localparam logic [3:0] IDX_DRIVE_PINS = 4'hC;
  localparam logic [7:0] CMD_DUMPREG = 8'h0E;
  localparam logic [7:0] CMD_PERP = 8'h12;
  localparam logic [6:0] CMD_LOCK_LOW = 7'h14;
  localparam logic [7:0] CMD_SENSE = 8'h04;
  localparam logic [7:0] CMD_SPECIFY = 8'h03;
  localparam logic [7:0] INVALID_ST0 = 8'h80;
  localparam int LOCK_RESULT_BIT = 4;
  localparam int CFG9_THREE_MODE_BIT = 0;
  localparam logic [7:0] MOTOR_SEL_RESET = 8'h00;
  localparam logic [7:0] SPEC1_RESET = 8'h00;
  localparam logic [7:0] SPEC2_RESET = 8'h00;
  localparam logic [7:0] EOT_RESET = 8'h00;
  localparam logic [7:0] PRECOMP_START_TRACK_RESET = 8'h00;
  localparam int DUMP_LEN = 10;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {CMD_IDLE, CMD_PARAM, CMD_RESULT} cmd_state_t;
endpackage

// >>> verif/drive_bay_model.sv
// drive-side model: floppy and tape drive pin levels seen by the register bank
// assumes the bench names wanted levels; they appear one pclk later
`timescale 1ns/100ps
`default_nettype none
module drive_bay_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [19:0] want,
  output logic [19:0] pins
);
  // levels move only just after an edge, so status reads never see a half-changed set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= 20'h00000;
    end else begin
      pins <= want;
    end
  end
endmodule // drive_bay_model
`default_nettype wire

// >>> verif/fhsr_asserts.sv
// checker on the apb side and output register of the register bank
// assumes one pclk domain; bound into floppy_host_status_regs below
`timescale 1ns/100ps
`default_nettype none
module fhsr_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic master_reset_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_out,
  input wire logic [7:0] motor_select_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable && pready;
  AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_READY_AFTER_ACCESS: assert property (psel && penable && !pready |=> pready)
    else $error("no answer to access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_STATUS_WRITE_REFUSED: assert property (acc && pwrite && paddr[31:3] == 29'h0 |-> pslverr)
    else $error("status write accepted");
  AST_OUTPUT_READ_REFUSED: assert property (acc && !pwrite && paddr[31:2] == 30'h2
    |-> pslverr && prdata == 32'h0) else $error("output register readable");
  AST_HOLE_REFUSED: assert property (acc && paddr[31:2] == 30'h6 |-> pslverr)
    else $error("hole accepted");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_MASTER_RESET: assert property (master_reset_pin |=> motor_select_q == 8'h00)
    else $error("output register kept");
  AST_IRQ_BIT: assert property (acc && !pwrite && paddr[31:2] == 30'h0
    |-> prdata[7] == $past(irq_out)) else $error("irq bit wrong");
endmodule // fhsr_asserts
bind floppy_host_status_regs fhsr_asserts chk (.pclk(pclk), .presetn(presetn),
  .master_reset_pin(master_reset_pin), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_out(irq_out),
  .motor_select_q(motor_select_q));
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the floppy register bank
// assumes one-wait apb3 slave and pins from drive_bay_model
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic master_reset_pin = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, lock, stby;
  logic [19:0] want = 20'h0;
  logic [19:0] pins, w;
  logic [7:0] msel, perp, v, c7, c8, sa, sb, pv;
  logic [16:0] exp_q[$];
  logic [16:0] ent;
  logic wt = 1'b0;
  logic rt = 1'b0;
  int fail_count = 0;
  int checked = 0;
  int seed = 82;
  always #5 pclk = ~pclk;
  floppy_host_status_regs dut (
    .pclk(pclk), .presetn(presetn), .master_reset_pin(master_reset_pin), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_out(pins[7]), .dma_request_out(pins[8]),
    .second_drive_absent(pins[6]), .step_out(pins[5]), .track_zero_input(pins[4]),
    .head_out(pins[3]), .index_in(pins[2]), .write_protect_n(pins[1]), .dir_out(pins[0]),
    .write_data_out(pins[9]), .read_data_in(pins[10]), .write_enable_out(pins[11]),
    .drive_status_3(pins[19:12]), .motor_select_q(msel), .perp_setting_q(perp),
    .lock_q(lock), .standby_q(stby));
  drive_bay_model partner (.pclk(pclk), .presetn(presetn), .want(want), .pins(pins));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // d is write data, or expected read data under mask m
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] d,
      input logic [7:0] m, input logic e);
    int n;
    @(posedge pclk);
    exp_q.push_back({m, e, d});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {26'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      fail_count++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // toggle bits follow every rising edge the design can see
  task automatic pins_to(input logic [19:0] p);
    if (p[9] && !want[9]) wt = ~wt;
    if (p[10] && !want[10]) rt = ~rt;
    want <= p;
    repeat (3) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      ent = exp_q.pop_front();
      check("prdata", prdata[7:0] & ent[16:9], ent[7:0] & ent[16:9]);
      check("pslverr", {7'h00, pslverr}, {7'h00, ent[8]});
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    check("motor_select_q", msel, 8'h00);
    apb(1'b1, 4'h0, 8'h00, 8'hFF, 1'b1);
    apb(1'b1, 4'h1, 8'h00, 8'hFF, 1'b1);
    apb(1'b0, 4'h2, 8'h00, 8'hFF, 1'b1);
    apb(1'b0, 4'h6, 8'h00, 8'hFF, 1'b1);
    v = 8'($random(seed)) | 8'h04;
    apb(1'b1, 4'h2, v, 8'h00, 1'b0);
    @(posedge pclk);
    check("motor_select_q", msel, v);
    master_reset_pin <= 1'b1;
    @(posedge pclk);
    master_reset_pin <= 1'b0;
    repeat (2) @(posedge pclk);
    check("motor_select_q", msel, 8'h00);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 4'h8, m[7:0], 8'h00, 1'b0);
      for (int k = 0; k < 6; k++) begin
        v = 8'($random(seed)) | 8'h04;
        apb(1'b1, 4'h2, v, 8'h00, 1'b0);
        pins_to(20'($random(seed)));
        w = want;
        sa = m ? {w[7], w[8], 1'b0, ~w[4], w[3], ~w[2], ~w[1], ~w[0]}
               : {w[7:6], ~w[5], w[4], ~w[3], w[2:0]};
        sb = m ? {w[6], 5'h00, v[1:0] != 2'd3, v[1:0] != 2'd2}
               : {2'b00, v[0], wt, rt, ~w[11], v[5:4]};
        apb(1'b0, 4'h0, sa, m ? 8'hDF : 8'hFF, 1'b0);
        apb(1'b0, 4'h1, sb, m ? 8'h83 : 8'h3F, 1'b0);
      end
    end
    v = 8'($random(seed));
    apb(1'b1, 4'h3, v, 8'h00, 1'b0);
    apb(1'b0, 4'h3, v, 8'h03, 1'b0);
    c7 = 8'($random(seed));
    c8 = 8'($random(seed));
    apb(1'b1, 4'h9, c7, 8'h00, 1'b0);
    apb(1'b1, 4'hA, c8, 8'h00, 1'b0);
    apb(1'b1, 4'hB, 8'h01, 8'h00, 1'b0);
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, 4'h2, 8'h04 | d[7:0], 8'h00, 1'b0);
      apb(1'b0, 4'h3, {c8[3:2], c7[2*d+1 -: 2], c8[1:0], v[1:0]}, 8'hFF, 1'b0);
    end
    for (int l = 0; l < 2; l++) begin
      apb(1'b1, 4'h5, {l[0], 7'h14}, 8'h00, 1'b0);
      apb(1'b0, 4'h5, {3'b000, l[0], 4'h0}, 8'hFF, 1'b0);
      check("lock_q", {7'h00, lock}, {7'h00, l[0]});
    end
    pv = 8'($random(seed)) & 8'hBF;
    apb(1'b1, 4'h5, 8'h12, 8'h00, 1'b0);
    apb(1'b1, 4'h5, pv, 8'h00, 1'b0);
    @(posedge pclk);
    check("perp_setting_q", perp & 8'hBF, pv);
    v = {5'h00, 3'($random(seed))};
    apb(1'b1, 4'h5, 8'h04, 8'h00, 1'b0);
    apb(1'b1, 4'h5, v, 8'h00, 1'b0);
    apb(1'b0, 4'h5, {want[19:15], v[2:0]}, 8'hFF, 1'b0);
    apb(1'b1, 4'h5, 8'hFF, 8'h00, 1'b0);
    @(posedge pclk);
    check("standby_q", {7'h00, stby}, 8'h01);
    apb(1'b0, 4'h5, 8'h80, 8'hFF, 1'b0);
    apb(1'b1, 4'h5, 8'h03, 8'h00, 1'b0);
    apb(1'b1, 4'h5, c7, 8'h00, 1'b0);
    apb(1'b1, 4'h5, c8, 8'h00, 1'b0);
    apb(1'b1, 4'h5, 8'h0E, 8'h00, 1'b0);
    for (int b = 0; b < 10; b++) begin
      v = 8'({16'h0, 2'b10, pv[5:0], 8'h00, c8, c7, 32'h0} >> (b * 8));
      apb(1'b0, 4'h5, v, b == 8 ? 8'h00 : 8'hFF, 1'b0);
    end
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
